// >>> common/chan_status_pkg.sv
package chan_status_pkg;

    // Register offsets
    localparam logic [7:0] OFS_PART_HIGH = 8'h30;
    localparam logic [7:0] OFS_PART_LOW = 8'h31;
    localparam logic [7:0] OFS_STRAP = 8'h40;
    localparam logic [7:0] OFS_PIN_LEVEL = 8'h41;
    localparam logic [7:0] OFS_TOP_SUM = 8'h42;
    localparam logic [7:0] OFS_CHIP_SUM = 8'h43;
    localparam logic [7:0] OFS_INPUT_SUM = 8'h44;
    localparam logic [7:0] OFS_OUTPUT_SUM = 8'h45;
    localparam logic [7:0] OFS_ALOOP_SUM = 8'h46;
    localparam logic [7:0] OFS_DLOOP_SUM = 8'h47;
    localparam logic [7:0] OFS_ALOOP_STAT = 8'h48;
    localparam logic [7:0] OFS_PA_STAT = 8'h50;
    localparam logic [7:0] OFS_MEAS_STAT = 8'h51;
    localparam logic [7:0] OFS_VALID_STAT1 = 8'h52;
    localparam logic [7:0] OFS_VALID_STAT2 = 8'h53;
    localparam logic [7:0] OFS_OUT1_STAT = 8'h54;
    localparam logic [7:0] OFS_OUT2_STAT = 8'h55;
    localparam logic [7:0] OFS_OUT3_STAT = 8'h56;
    localparam logic [7:0] OFS_DLOOP_STAT = 8'h57;

    // Identity values are arbitrary
    localparam logic [7:0] PART_CODE_HIGH = 8'h5A;
    localparam logic [3:0] PART_CODE_LOW = 4'hC;
    localparam logic [3:0] SILICON_VERSION = 4'h0;

    // Field positions
    localparam int TOP_CHIP_BIT = 6;
    localparam int TOP_OUT_BIT = 5;
    localparam int TOP_IN_BIT = 4;
    localparam int TOP_DLOOP_BIT = 3;
    localparam int TOP_ALOOP_BIT = 2;
    localparam int TOP_IE_BIT = 1;
    localparam int TOP_PEND_BIT = 0;
    localparam int BOOT_DONE_BIT = 7;
    localparam int TEST_STRAP_BIT = 7;
    localparam int OSC_FAULT_BIT = 6;

    // Reset values
    localparam logic RESET_IE = 1'b0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Latch groups: phase, measure, valid1, valid2, out1..3, aloop, dloop
    localparam int NUM_GROUPS = 9;

endpackage

// >>> common/latch_grp_if.sv
`timescale 1ns/1ps
interface latch_grp_if;
    logic [3:0] live;
    logic [3:0] clr_mask;
    logic [3:0] ie;
    logic [3:0] latched;
    logic active;
    modport owner (input live, input clr_mask, input ie, output latched, output active);
    modport user (output live, output clr_mask, output ie, input latched, input active);
endinterface

// >>> rtl/change_latch.sv
`timescale 1ns/1ps
module change_latch
(
    input wire logic mclk, // Master clock
    input wire logic nrst, // Sync reset, active low
    latch_grp_if.owner grp // Live status in, latched flags out
);
    logic [3:0] prev_q;
    logic [3:0] latched_q;

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            prev_q <= 4'h0;
        else
            prev_q <= grp.live;
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            latched_q <= 4'h0;
        else
            latched_q <= (latched_q & ~grp.clr_mask) | (grp.live ^ prev_q);
    end

    assign grp.latched = latched_q;
    assign grp.active = |(latched_q & grp.ie);
endmodule

// >>> rtl/channel_status_irq_summary.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Part code high byte reads as a constant, same in every channel.
// - Part code low nibble sits in bits 7 to 4 of second id register.
// - Silicon version sits in bits 3 to 0, first version is zero.
// - Test strap caught into bit 7 on chip reset release; should read zero.
// - Oscillator fault bit follows fault, forced zero while ring osc disabled.
// - Two host-port straps caught into bits 3 to 2 on reset release.
// - Two auto-config straps caught into bits 1 to 0 on reset release.
// - Bits 3 to 0 show raw pin levels, ignoring configured inversion.
// - Top bit 6 set when the phase-adjust or edge-measurement chip-wide summary bit is set.
// - Top bit 5 set when any output-clock summary bit is set.
// - Top bit 4 set when any input-clock summary bit is set.
// - Top bit 3 set when the digital-loop summary is set.
// - Top bit 2 set when the analog-loop summary is set.
// - Writable global enable at bit 1; zero blocks the pending bit.
// - Pending bit 0 set when any summary is set and enable is one.
// - Boot-complete bit cleared on channel reset, set when boot loader finishes.
// - Phase-adjust summary set while an enabled phase latch is set.
// - Edge-measurement summary set while an enabled measurement latch is set.
// - Input-3 summary set while its validity latch and enable are set.
// - Input-1 and input-2 summaries follow their enabled validity latches.
// - Each output summary set while any enabled latch of that output is set.
// - Latches set on live status change; software writes one to clear.
module channel_status_irq_summary
(
    input wire logic mclk, // Master clock, 200 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
    input wire logic chip_reset_n, // Chip reset pin level, straps caught on its rise
    input wire logic test_strap, // Factory test strap pin
    input wire logic [1:0] host_port_strap, // Host-port selection straps
    input wire logic [1:0] auto_config_strap, // Auto-configuration straps
    input wire logic osc_fail, // Oscillator stopped, from detector
    input wire logic ring_osc_disable, // Ring oscillator disabled control
    input wire logic gp_pin0_level, // General-purpose pin 0
    input wire logic gp_pin1_level, // General-purpose pin 1
    input wire logic gp_pin2_level, // General-purpose pin 2
    input wire logic gp_pin3_level, // General-purpose pin 3
    input wire logic boot_loader_finished, // Pulse or level: boot loader done
    input wire logic [3:0] phase_adjust_live, // Live phase-adjust status
    input wire logic [3:0] edge_meas_live, // Live measurement status
    input wire logic [1:0] input_valid_live, // Live validity of inputs 1 and 2
    input wire logic input3_valid_live, // Live validity of input 3
    input wire logic [3:0] out1_live, // Live status of output 1
    input wire logic [3:0] out2_live, // Live status of output 2
    input wire logic [3:0] out3_live, // Live status of output 3
    input wire logic [1:0] aloop_live, // Live analog-loop lock statuses
    input wire logic [3:0] dloop_live, // Live digital-loop status
    output logic irq_pending // Top pending bit, for a pin to follow
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [11:0] pin_s1_q;
    logic [11:0] pin_s2_q;
    logic [11:0] pin_raw;

    assign pin_raw = {ring_osc_disable, osc_fail, chip_reset_n, test_strap, host_port_strap, auto_config_strap,
                      gp_pin3_level, gp_pin2_level, gp_pin1_level, gp_pin0_level};

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            pin_s1_q <= 12'h000;
            pin_s2_q <= 12'h000;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    logic rosc_dis_s;
    logic osc_fail_s;
    logic chip_rst_s;
    logic [4:0] strap_s;
    logic [3:0] gp_s;

    assign rosc_dis_s = pin_s2_q[11];
    assign osc_fail_s = pin_s2_q[10];
    assign chip_rst_s = pin_s2_q[9];
    assign strap_s = pin_s2_q[8:4];
    assign gp_s = pin_s2_q[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Strap capture on chip reset release
    logic chip_rst_prev_q;
    logic [4:0] strap_q;

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            chip_rst_prev_q <= 1'b0;
        else
            chip_rst_prev_q <= chip_rst_s;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            strap_q <= 5'h00;
        else if (chip_rst_s && !chip_rst_prev_q)
            strap_q <= strap_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot-complete flag
    logic boot_done_q;

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            boot_done_q <= 1'b0;
        else if (boot_loader_finished)
            boot_done_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch groups and their enables
    latch_grp_if grp [chan_status_pkg::NUM_GROUPS] ();
    logic [7:0] ie_q [chan_status_pkg::NUM_GROUPS];
    logic [3:0] live_v [chan_status_pkg::NUM_GROUPS];
    logic [7:0] ofs_v [chan_status_pkg::NUM_GROUPS];
    logic [chan_status_pkg::NUM_GROUPS-1:0] act_v;
    logic [3:0] lat_v [chan_status_pkg::NUM_GROUPS];

    assign live_v[0] = phase_adjust_live;
    assign live_v[1] = edge_meas_live;
    assign live_v[2] = {2'b00, input_valid_live};
    assign live_v[3] = {3'b000, input3_valid_live};
    assign live_v[4] = out1_live;
    assign live_v[5] = out2_live;
    assign live_v[6] = out3_live;
    assign live_v[7] = {2'b00, aloop_live};
    assign live_v[8] = dloop_live;

    assign ofs_v[0] = chan_status_pkg::OFS_PA_STAT;
    assign ofs_v[1] = chan_status_pkg::OFS_MEAS_STAT;
    assign ofs_v[2] = chan_status_pkg::OFS_VALID_STAT1;
    assign ofs_v[3] = chan_status_pkg::OFS_VALID_STAT2;
    assign ofs_v[4] = chan_status_pkg::OFS_OUT1_STAT;
    assign ofs_v[5] = chan_status_pkg::OFS_OUT2_STAT;
    assign ofs_v[6] = chan_status_pkg::OFS_OUT3_STAT;
    assign ofs_v[7] = chan_status_pkg::OFS_ALOOP_STAT;
    assign ofs_v[8] = chan_status_pkg::OFS_DLOOP_STAT;

    // Status byte layout: [7:4] enables, [3:0] latched flags (write one clears)
    genvar gi;
    generate
        for (gi = 0; gi < chan_status_pkg::NUM_GROUPS; gi++)
        begin : g_grp
            logic hit;
            assign hit = reg_wr && (reg_addr == ofs_v[gi]);
            assign grp[gi].live = live_v[gi];
            assign grp[gi].ie = ie_q[gi][7:4];
            assign grp[gi].clr_mask = hit ? reg_wdata[3:0] : 4'h0;
            assign act_v[gi] = grp[gi].active;
            assign lat_v[gi] = grp[gi].latched;

            always_ff @(posedge mclk)
            begin
                if (!nrst)
                    ie_q[gi] <= chan_status_pkg::RESET_BYTE;
                else if (hit)
                    ie_q[gi] <= {reg_wdata[7:4], 4'h0};
            end

            change_latch u_latch
            (
                .mclk(mclk),
                .nrst(nrst),
                .grp(grp[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Summary tree
    logic [7:0] chip_sum;
    logic [7:0] input_sum;
    logic [7:0] output_sum;
    logic [7:0] aloop_sum;
    logic [7:0] dloop_sum;
    logic [7:0] top_sum;
    logic [7:0] strap_byte;
    logic [7:0] pin_byte;
    logic global_ie_q;
    logic any_sum;

    assign chip_sum = {boot_done_q, 5'h00, act_v[0], act_v[1]};
    assign input_sum = {5'h00, act_v[3], grp[2].latched[1] & grp[2].ie[1],
                        grp[2].latched[0] & grp[2].ie[0]};
    assign output_sum = {5'h00, act_v[6], act_v[5], act_v[4]};
    assign aloop_sum = {7'h00, act_v[7]};
    assign dloop_sum = {7'h00, act_v[8]};

    // Boot-complete is status, not an interrupt source
    assign any_sum = (|chip_sum[1:0]) | (|output_sum) | (|input_sum) | dloop_sum[0] | aloop_sum[0];

    always_comb
    begin
        top_sum = 8'h00;
        top_sum[chan_status_pkg::TOP_CHIP_BIT] = |chip_sum[1:0];
        top_sum[chan_status_pkg::TOP_OUT_BIT] = |output_sum;
        top_sum[chan_status_pkg::TOP_IN_BIT] = |input_sum;
        top_sum[chan_status_pkg::TOP_DLOOP_BIT] = dloop_sum[0];
        top_sum[chan_status_pkg::TOP_ALOOP_BIT] = aloop_sum[0];
        top_sum[chan_status_pkg::TOP_IE_BIT] = global_ie_q;
        top_sum[chan_status_pkg::TOP_PEND_BIT] = any_sum & global_ie_q;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            global_ie_q <= chan_status_pkg::RESET_IE;
        else if (reg_wr && reg_addr == chan_status_pkg::OFS_TOP_SUM)
            global_ie_q <= reg_wdata[chan_status_pkg::TOP_IE_BIT];
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            irq_pending <= 1'b0;
        else
            irq_pending <= any_sum & global_ie_q;
    end

    always_comb
    begin
        strap_byte = 8'h00;
        strap_byte[chan_status_pkg::TEST_STRAP_BIT] = strap_q[4];
        strap_byte[chan_status_pkg::OSC_FAULT_BIT] = osc_fail_s & ~rosc_dis_s;
        strap_byte[3:0] = strap_q[3:0];
        pin_byte = {4'h0, gp_s};
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port
    logic [7:0] rd_d;

    always_comb
    begin
        rd_d = 8'h00;
        case (reg_addr)
            chan_status_pkg::OFS_PART_HIGH: rd_d = chan_status_pkg::PART_CODE_HIGH;
            chan_status_pkg::OFS_PART_LOW: rd_d = {chan_status_pkg::PART_CODE_LOW,
                                                   chan_status_pkg::SILICON_VERSION};
            chan_status_pkg::OFS_STRAP: rd_d = strap_byte;
            chan_status_pkg::OFS_PIN_LEVEL: rd_d = pin_byte;
            chan_status_pkg::OFS_TOP_SUM: rd_d = top_sum;
            chan_status_pkg::OFS_CHIP_SUM: rd_d = chip_sum;
            chan_status_pkg::OFS_INPUT_SUM: rd_d = input_sum;
            chan_status_pkg::OFS_OUTPUT_SUM: rd_d = output_sum;
            chan_status_pkg::OFS_ALOOP_SUM: rd_d = aloop_sum;
            chan_status_pkg::OFS_DLOOP_SUM: rd_d = dloop_sum;
            default:
            begin
                for (int k = 0; k < chan_status_pkg::NUM_GROUPS; k++)
                begin
                    if (reg_addr == ofs_v[k])
                        rd_d = ie_q[k] | {4'h0, lat_v[k]};
                end
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_d;
    end
endmodule

// >>> verification/chan_status_monitor.sv
`timescale 1ns/1ps
module chan_status_monitor
(
    input wire logic mclk, // Master clock
    input wire logic nrst, // Sync reset, active low
    input wire logic [7:0] reg_addr, // Offset
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic ring_osc_disable, // Ring osc off
    input wire logic gp_pin0_level, // Pin 0
    input wire logic gp_pin1_level, // Pin 1
    input wire logic gp_pin2_level, // Pin 2
    input wire logic gp_pin3_level, // Pin 3
    input wire logic irq_pending // Pending output
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    wire logic [3:0] pins = {gp_pin3_level, gp_pin2_level, gp_pin1_level, gp_pin0_level};
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // Long enough for the pin synchronisers to settle
    sequence pins_settled;
        $stable(pins) [*6];
    endsequence
    chk_id_high: assert property (
        rd_at(chan_status_pkg::OFS_PART_HIGH) |=> reg_rdata == chan_status_pkg::PART_CODE_HIGH)
        else $error("part code high wrong");
    chk_id_low: assert property (
        rd_at(chan_status_pkg::OFS_PART_LOW) |=>
        reg_rdata == {chan_status_pkg::PART_CODE_LOW, chan_status_pkg::SILICON_VERSION})
        else $error("part code low wrong");
    chk_pin_level: assert property (
        pins_settled ##0 rd_at(chan_status_pkg::OFS_PIN_LEVEL) |=> reg_rdata == {4'h0, $past(pins)})
        else $error("pin levels wrong");
    chk_osc_masked: assert property (
        ring_osc_disable [*6] ##0 rd_at(chan_status_pkg::OFS_STRAP) |=> reg_rdata[6:4] == 3'h0)
        else $error("osc fault not masked");
    chk_pend_gate: assert property (
        rd_at(chan_status_pkg::OFS_TOP_SUM) |=> reg_rdata[0] == (reg_rdata[1] && |reg_rdata[6:2]) && !reg_rdata[7])
        else $error("pending bit inconsistent");
    chk_irq_follow: assert property (
        rd_at(chan_status_pkg::OFS_TOP_SUM) |=> irq_pending == reg_rdata[0])
        else $error("irq output differs from pending bit");
    chk_input_resv: assert property (
        rd_at(chan_status_pkg::OFS_INPUT_SUM) |=> reg_rdata[7:3] == 5'h00)
        else $error("input summary reserved bits set");
    chk_chip_resv: assert property (
        rd_at(chan_status_pkg::OFS_CHIP_SUM) |=> reg_rdata[6:2] == 5'h00)
        else $error("chip summary reserved bits set");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr >= 8'h58 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

// >>> verification/channel_status_irq_summary_tb.sv
`timescale 1ns/1ps
module channel_status_irq_summary_tb;
    logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, chip_reset_n = 1'h0, test_strap = 1'h1;
    logic osc_fail = 1'h0, ring_osc_disable = 1'h0, boot_loader_finished = 1'h0, input3_valid_live = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_val;
    logic [1:0] host_port_strap = 2'h2, auto_config_strap = 2'h1, input_valid_live = 2'h0, aloop_live = 2'h0;
    logic [3:0] pins = 4'h0, phase_adjust_live = 4'h0, edge_meas_live = 4'h0, dloop_live = 4'h0;
    logic [3:0] out1_live = 4'h0, out2_live = 4'h0, out3_live = 4'h0;
    wire logic [7:0] reg_rdata;
    wire logic irq_pending;
    int mismatches = 0;
    int n_checks = 0;
    always #2.5 mclk = ~mclk;
    channel_status_irq_summary dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chip_reset_n(chip_reset_n),
        .test_strap(test_strap), .host_port_strap(host_port_strap), .auto_config_strap(auto_config_strap),
        .osc_fail(osc_fail), .ring_osc_disable(ring_osc_disable), .gp_pin0_level(pins[0]),
        .gp_pin1_level(pins[1]), .gp_pin2_level(pins[2]), .gp_pin3_level(pins[3]),
        .boot_loader_finished(boot_loader_finished), .phase_adjust_live(phase_adjust_live),
        .edge_meas_live(edge_meas_live), .input_valid_live(input_valid_live),
        .input3_valid_live(input3_valid_live), .out1_live(out1_live), .out2_live(out2_live),
        .out3_live(out3_live), .aloop_live(aloop_live), .dloop_live(dloop_live), .irq_pending(irq_pending));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    task automatic rdc(string what, logic [7:0] a, logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 rd_val = reg_rdata;
        cmp(what, exp, rd_val);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_ids();
        rdc("part high", chan_status_pkg::OFS_PART_HIGH, chan_status_pkg::PART_CODE_HIGH);
        rdc("part low", chan_status_pkg::OFS_PART_LOW, {chan_status_pkg::PART_CODE_LOW, 4'h0});
        wr(chan_status_pkg::OFS_PART_HIGH, 8'h00);
        rdc("part high ro", chan_status_pkg::OFS_PART_HIGH, chan_status_pkg::PART_CODE_HIGH);
        rdc("unmapped", 8'h60, 8'h00);
    endtask
    task automatic test_straps();
        @(posedge mclk);
        chip_reset_n <= 1'h1;
        repeat (6) @(posedge mclk);
        test_strap <= 1'h0;
        host_port_strap <= 2'h1;
        auto_config_strap <= 2'h2;
        rdc("straps", chan_status_pkg::OFS_STRAP, 8'h89);
    endtask
    task automatic test_osc();
        @(posedge mclk);
        osc_fail <= 1'h1;
        repeat (5) @(posedge mclk);
        rdc("osc fault", chan_status_pkg::OFS_STRAP, 8'hC9);
        @(posedge mclk);
        ring_osc_disable <= 1'h1;
        repeat (7) @(posedge mclk);
        rdc("osc masked", chan_status_pkg::OFS_STRAP, 8'h89);
        @(posedge mclk);
        osc_fail <= 1'h0;
        ring_osc_disable <= 1'h0;
    endtask
    task automatic test_pins();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            pins <= 4'h1 << i;
            repeat (7) @(posedge mclk);
            rdc("pins", chan_status_pkg::OFS_PIN_LEVEL, 8'h01 << i);
        end
    endtask
    task automatic poke(int g);
        @(posedge mclk);
        case (g)
            0: phase_adjust_live <= 4'h8;
            1: edge_meas_live <= 4'h1;
            2: input_valid_live <= 2'h3;
            3: input3_valid_live <= 1'h1;
            4: out1_live <= 4'h4;
            5: out2_live <= 4'h1;
            6: out3_live <= 4'h2;
            7: aloop_live <= 2'h2;
            default: dloop_live <= 4'h8;
        endcase
    endtask
    task automatic test_tree();
        logic [7:0] own[9] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h48, 8'h57};
        logic [7:0] sum[9] = '{8'h43, 8'h43, 8'h44, 8'h44, 8'h45, 8'h45, 8'h45, 8'h46, 8'h47};
        logic [7:0] sbit[9] = '{8'h02, 8'h01, 8'h03, 8'h04, 8'h01, 8'h02, 8'h04, 8'h01, 8'h01};
        logic [7:0] flag[9] = '{8'h08, 8'h01, 8'h03, 8'h01, 8'h04, 8'h01, 8'h02, 8'h02, 8'h08};
        int topb[9] = '{6, 6, 4, 4, 5, 5, 5, 2, 3};
        logic [7:0] ie;
        for (int g = 0; g < 9; g++)
        begin
            ie = (g % 2 == 1) ? 8'h02 : 8'h00;
            wr(chan_status_pkg::OFS_TOP_SUM, 8'hFC | ie);
            rdc("top idle", chan_status_pkg::OFS_TOP_SUM, ie);
            poke(g);
            repeat (3) @(posedge mclk);
            rdc("sum masked", sum[g], 8'h00);
            wr(own[g], 8'hF0);
            rdc("sum set", sum[g], sbit[g]);
            rdc("own set", own[g], 8'hF0 | flag[g]);
            rdc("top set", chan_status_pkg::OFS_TOP_SUM, (8'h01 << topb[g]) | ie | (ie >> 1));
            cmp("irq", {7'h00, ie[1]}, {7'h00, irq_pending});
            wr(own[g], 8'hFF);
            rdc("sum clear", sum[g], 8'h00);
            rdc("own clear", own[g], 8'hF0);
            rdc("top clear", chan_status_pkg::OFS_TOP_SUM, ie);
            wr(own[g], 8'h00);
        end
    endtask
    task automatic test_boot();
        rdc("boot idle", chan_status_pkg::OFS_CHIP_SUM, 8'h00);
        @(posedge mclk);
        boot_loader_finished <= 1'h1;
        @(posedge mclk);
        boot_loader_finished <= 1'h0;
        repeat (2) @(posedge mclk);
        rdc("boot done", chan_status_pkg::OFS_CHIP_SUM, 8'h80);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge mclk);
        nrst <= 1'h1;
        repeat (2) @(posedge mclk);
        test_ids();
        test_straps();
        test_osc();
        test_pins();
        test_tree();
        test_boot();
        conclude();
    end
    // Whole run needs well under 2000 cycles
    initial
    begin
        #20000;
        mismatches++;
        conclude();
    end
endmodule

bind channel_status_irq_summary chan_status_monitor mon (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ring_osc_disable(ring_osc_disable),
    .gp_pin0_level(gp_pin0_level), .gp_pin1_level(gp_pin1_level), .gp_pin2_level(gp_pin2_level),
    .gp_pin3_level(gp_pin3_level), .irq_pending(irq_pending));
